// ==== hdl/blink_gen.sv ====
/*
 * Single blink source; all flashing LEDs use this phase or its inverse.
 * Assumes synchronous inputs and an asynchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
`include "led_consts.svh"
module blink_gen #(
	parameter int unsigned HALF_CYC = `BLINK_HALF_CYC
) (
	input wire logic   sys_clk,
	input wire logic   reset,
	diag_if.blink_src  diag
);
	typedef struct packed {
		logic [31:0] cnt;
		logic        phase;
	} st_t;

	st_t st_q;
	st_t st_d;

	always_comb begin
		st_d = st_q;
		if (st_q.cnt >= 32'(HALF_CYC - 1)) begin
			st_d.cnt   = '0;
			st_d.phase = ~st_q.phase;
		end else begin
			st_d.cnt = st_q.cnt + 32'h1;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign diag.blink = st_q.phase;

	property p_blink_hold;
		@(posedge sys_clk) disable iff (reset)
		(st_q.cnt < 32'(HALF_CYC - 1)) |=> $stable(diag.blink);
	endproperty
	a_blink_hold: assert property (p_blink_hold) else $error("blink phase moved early");
endmodule
`default_nettype wire

// ==== hdl/diag_if.sv ====
/*
 * Carrier between the indicator core, its blink source and its quiet timer.
 * Assumes all parties share sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none
interface diag_if;
	logic blink;
	logic il_arm;
	logic il_quiet;
	logic il_done;

	modport blink_src (output blink);
	modport timer     (input il_arm, input il_quiet, output il_done);
	modport core      (input blink, input il_done, output il_arm, output il_quiet);
endinterface
`default_nettype wire

// ==== hdl/led_consts.svh ====
/*
 * Constants of the safety-relay LED indicator: sizes, timing counts.
 * Assumes a 25 MHz system clock; included by bare name.
 */
// Contract
// - State LED steady while safety outputs active, dark when deactivated.
// - Start LED dark when unmet, steady when met, flashing while waiting.
// - Each safety input LED follows its input outside alert or error display.
// - Alert flashes the error LED with a pattern on related input LEDs.
// - Any alert forces the safety outputs into the safe state.
// - Alert safe state ends once the cause is gone, no power cycle.
// - Synchronisation timeout: error LED flashes, two input LEDs flash alternately.
// - Interlock: LEDs flash in phase; outputs off until inputs quiet 1 s.
// - Detected error lights error LED steady, shows a pattern, forces safe state.
// - Detected error stays latched until power is cycled.
// - Configuration error: other LEDs steady; general error: flashing in phase.
// - Supply error: error LED steady, power LED flashing.
// - Output fault: error LED steady, state LED flashing.
// - Start input cross circuit: error LED steady, start LED flashing.
// - One input cross circuit: error LED steady, only that input LED flashes.
// - Two-input cross circuit: error LED steady, both input LEDs flash in phase.
// - Selector change while powered raises configuration error; effective next power-up.
`ifndef LED_CONSTS_SVH
`define LED_CONSTS_SVH

`define CLK_HZ         25000000
`define NUM_SAFETY_IN  2
`define SEL_WIDTH      4
`define BLINK_HALF_MS  250
`define BLINK_HALF_CYC ((`CLK_HZ / 1000) * `BLINK_HALF_MS)
`define INTERLOCK_MS   1000
`define INTERLOCK_CYC  ((`CLK_HZ / 1000) * `INTERLOCK_MS)

`endif

// ==== hdl/led_pkg.sv ====
/*
 * Types shared by the LED indicator modules.
 * Assumes nothing of its surroundings.
 */
package led_pkg;
	// Kind of latched detected error; first member is the idle value
	typedef enum logic [2:0] {
		ERR_NONE,
		ERR_CONFIG,
		ERR_GENERAL,
		ERR_EXT,
		ERR_SUPPLY,
		ERR_OUTPUT,
		ERR_START_XC,
		ERR_INPUT_XC
	} err_kind_t;
endpackage

// ==== hdl/quiet_timer.sv ====
/*
 * Measures how long both interlocked inputs stay deactivated.
 * Assumes the core holds il_arm for the whole interlock alert.
 */
`timescale 1ns/10ps
`default_nettype none
`include "led_consts.svh"
module quiet_timer #(
	parameter int unsigned QUIET_CYC = `INTERLOCK_CYC
) (
	input wire logic sys_clk,
	input wire logic reset,
	diag_if.timer    diag
);
	typedef struct packed {
		logic [31:0] cnt;
		logic        done;
	} st_t;

	st_t st_q;
	st_t st_d;

	// Any activation restarts the full quiet period
	always_comb begin
		st_d = st_q;
		if (!diag.il_arm || !diag.il_quiet) begin
			st_d.cnt  = '0;
			st_d.done = 1'b0;
		end else if (st_q.cnt >= 32'(QUIET_CYC - 1)) begin
			st_d.done = 1'b1;
		end else begin
			st_d.cnt = st_q.cnt + 32'h1;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign diag.il_done = st_q.done;

	property p_quiet_done;
		@(posedge sys_clk) disable iff (reset)
		diag.il_done |-> $past(diag.il_arm) && $past(diag.il_quiet) && (st_q.cnt == 32'(QUIET_CYC - 1));
	endproperty
	a_quiet_done: assert property (p_quiet_done) else $error("quiet done without full quiet period");
endmodule
`default_nettype wire

// ==== hdl/safety_diag_led_indicator.sv ====
/*
 * Front-panel LED driver and safe-state gate of a safety relay.
 * Assumes status inputs synchronous to sys_clk; reset stands for power-up.
 */
`timescale 1ns/10ps
`default_nettype none
`include "led_consts.svh"
module safety_diag_led_indicator
	import led_pkg::*;
#(
	parameter int unsigned NUM_IN         = `NUM_SAFETY_IN,
	parameter int unsigned SEL_W          = `SEL_WIDTH,
	parameter int unsigned BLINK_HALF_CYC = `BLINK_HALF_CYC,
	parameter int unsigned INTERLOCK_CYC  = `INTERLOCK_CYC
) (
	input  wire logic              sys_clk,
	input  wire logic              reset,
	input  wire logic              supply_ok,
	input  wire logic              out_request,
	input  wire logic              start_met,
	input  wire logic              start_wait,
	input  wire logic [NUM_IN-1:0] safety_in,
	input  wire logic              sync_timeout,
	input  wire logic              interlock_det,
	input  wire logic [NUM_IN-1:0] alert_pair,
	input  wire logic              supply_err,
	input  wire logic              output_fault,
	input  wire logic              ext_output_fault,
	input  wire logic              general_err,
	input  wire logic              start_xc,
	input  wire logic [NUM_IN-1:0] input_xc,
	input  wire logic [SEL_W-1:0]  app_sel,
	input  wire logic [SEL_W-1:0]  start_sel,
	output logic                   outputs_on,
	output logic                   led_power,
	output logic                   led_state,
	output logic                   led_start,
	output logic [NUM_IN-1:0]      led_in,
	output logic                   led_error
);
	// ==========================================================
	// State
	typedef struct packed {
		err_kind_t         err;
		logic [NUM_IN-1:0] xc_mask;
		logic [NUM_IN-1:0] il_pair;
		logic              il;
		logic              cfg_valid;
		logic [SEL_W-1:0]  app_sel;
		logic [SEL_W-1:0]  start_sel;
		logic              outputs_on;
		logic              led_power;
		logic              led_state;
		logic              led_start;
		logic [NUM_IN-1:0] led_in;
		logic              led_error;
	} st_t;

	st_t st_q;
	st_t st_d;

	diag_if diag ();

	blink_gen #(
		.HALF_CYC (BLINK_HALF_CYC)
	) u_blink (
		.sys_clk (sys_clk),
		.reset   (reset),
		.diag    (diag)
	);

	quiet_timer #(
		.QUIET_CYC (INTERLOCK_CYC)
	) u_quiet (
		.sys_clk (sys_clk),
		.reset   (reset),
		.diag    (diag)
	);

	// ==========================================================
	// Helpers
	function automatic logic [NUM_IN-1:0] lowest_set(input logic [NUM_IN-1:0] m);
		return m & (~m + NUM_IN'(1));
	endfunction

	// Picks one error when several arrive in the same cycle
	function automatic err_kind_t pick_error(
		input logic cfg, input logic gen, input logic ext, input logic sup,
		input logic outf, input logic sxc, input logic ixc);
		err_kind_t k;
		k = ERR_NONE;
		if (cfg) begin
			k = ERR_CONFIG;
		end else if (gen) begin
			k = ERR_GENERAL;
		end else if (ext) begin
			k = ERR_EXT;
		end else if (sup) begin
			k = ERR_SUPPLY;
		end else if (outf) begin
			k = ERR_OUTPUT;
		end else if (sxc) begin
			k = ERR_START_XC;
		end else if (ixc) begin
			k = ERR_INPUT_XC;
		end
		return k;
	endfunction

	logic              blink;
	logic [NUM_IN-1:0] blink_v;
	logic              sel_moved;
	logic              alert_c;
	logic [NUM_IN-1:0] lead;

	assign blink   = diag.blink;
	assign blink_v = {NUM_IN{blink}};
	assign lead    = lowest_set(alert_pair);

	// Only the selector changing after the power-up capture counts
	assign sel_moved = st_q.cfg_valid && ((app_sel != st_q.app_sel) || (start_sel != st_q.start_sel));

	assign diag.il_arm   = st_q.il;
	assign diag.il_quiet = ~|(safety_in & st_q.il_pair);

	// ==========================================================
	// Next state
	always_comb begin
		st_d = st_q;

		// Selectors are sampled once after power-up; later moves take effect only at the next power-up
		if (!st_q.cfg_valid) begin
			st_d.cfg_valid = 1'b1;
			st_d.app_sel   = app_sel;
			st_d.start_sel = start_sel;
		end

		// Errors latch; only reset releases them
		if (st_q.err == ERR_NONE) begin
			st_d.err = pick_error(sel_moved, general_err, ext_output_fault, supply_err,
				output_fault, start_xc, |input_xc);
			st_d.xc_mask = input_xc;
		end

		// A new detection wins over the release by the quiet timer
		if (interlock_det) begin
			st_d.il      = 1'b1;
			st_d.il_pair = alert_pair;
		end else if (st_q.il && diag.il_done) begin
			st_d.il = 1'b0;
		end

		alert_c = st_d.il || sync_timeout;

		st_d.outputs_on = out_request && !alert_c && (st_d.err == ERR_NONE);

		// Normal display
		st_d.led_power = supply_ok;
		st_d.led_state = st_d.outputs_on;
		st_d.led_error = 1'b0;
		st_d.led_in    = safety_in;
		if (start_met) begin
			st_d.led_start = 1'b1;
		end else begin
			st_d.led_start = start_wait && blink;
		end

		if (st_d.err != ERR_NONE) begin
			st_d.led_error = 1'b1;
			st_d.led_state = 1'b0;
			st_d.led_start = 1'b0;
			st_d.led_in    = '0;
			unique case (st_d.err)
				ERR_CONFIG: begin
					st_d.led_state = 1'b1;
					st_d.led_start = 1'b1;
					st_d.led_in    = '1;
				end
				ERR_GENERAL: begin
					st_d.led_state = blink;
					st_d.led_start = blink;
					st_d.led_in    = blink_v;
				end
				ERR_EXT: begin
					st_d.led_state = blink;
					st_d.led_start = blink;
				end
				ERR_SUPPLY: begin
					st_d.led_power = blink;
				end
				ERR_OUTPUT: begin
					st_d.led_state = blink;
				end
				ERR_START_XC: begin
					st_d.led_start = blink;
				end
				ERR_INPUT_XC: begin
					st_d.led_in = st_d.xc_mask & blink_v;
				end
				default: begin
					st_d.led_error = 1'b1;
				end
			endcase
		end else if (st_d.il) begin
			st_d.led_error = blink;
			st_d.led_in    = st_d.il_pair & blink_v;
		end else if (sync_timeout) begin
			st_d.led_error = blink;
			st_d.led_in    = (lead & blink_v) | (alert_pair & ~lead & ~blink_v);
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign outputs_on = st_q.outputs_on;
	assign led_power  = st_q.led_power;
	assign led_state  = st_q.led_state;
	assign led_start  = st_q.led_start;
	assign led_in     = st_q.led_in;
	assign led_error  = st_q.led_error;

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence s_alert_then_clear;
		alert_c ##1 (!alert_c && (st_d.err == ERR_NONE) && out_request);
	endsequence

	sequence s_quiet_release;
		(st_q.il && !interlock_det && diag.il_done);
	endsequence

	property p_state_led;
		(st_q.err == ERR_NONE) |-> (led_state == outputs_on);
	endproperty
	a_state_led: assert property (p_state_led) else $error("state LED differs from outputs");

	property p_start_led;
		(start_met && (st_d.err == ERR_NONE)) |=> led_start;
	endproperty
	a_start_led: assert property (p_start_led) else $error("start LED dark while condition met");

	property p_input_led;
		(st_d.err == ERR_NONE && !st_d.il && !sync_timeout) |=> (led_in == $past(safety_in));
	endproperty
	a_input_led: assert property (p_input_led) else $error("input LEDs do not follow inputs");

	property p_alert_safe;
		(sync_timeout || interlock_det) |=> !outputs_on && (!led_state || st_q.err != ERR_NONE);
	endproperty
	a_alert_safe: assert property (p_alert_safe) else $error("outputs on during alert");

	property p_resume;
		s_alert_then_clear |=> outputs_on;
	endproperty
	a_resume: assert property (p_resume) else $error("no resume after alert cause gone");

	property p_sync_alt;
		(sync_timeout && !st_d.il && st_d.err == ERR_NONE && $countones(alert_pair) == 2)
			|=> ($countones(led_in & $past(alert_pair)) == 1);
	endproperty
	a_sync_alt: assert property (p_sync_alt) else $error("sync alert pair not alternating");

	property p_il_release;
		s_quiet_release |=> !st_q.il
			##1 (out_request && !sync_timeout && !st_d.il && st_d.err == ERR_NONE) [*1] |=> outputs_on;
	endproperty
	a_il_release: assert property (p_il_release) else $error("interlock not released after quiet");

	property p_il_hold;
		st_q.il |-> !outputs_on ##0 (led_in & ~st_q.il_pair) == '0 || st_q.err != ERR_NONE;
	endproperty
	a_il_hold: assert property (p_il_hold) else $error("interlock alert lets outputs on");

	property p_err_led;
		(st_q.err != ERR_NONE) |-> led_error && !outputs_on;
	endproperty
	a_err_led: assert property (p_err_led) else $error("error without steady LED or safe state");

	property p_err_latch;
		(st_q.err != ERR_NONE) |=> (st_q.err == $past(st_q.err)) [*2];
	endproperty
	a_err_latch: assert property (p_err_latch) else $error("detected error released");

	property p_cfg_err;
		sel_moved |=> (st_q.err != ERR_NONE);
	endproperty
	a_cfg_err: assert property (p_cfg_err) else $error("selector move not flagged");

	property p_supply_blink;
		(st_q.err == ERR_SUPPLY) |-> (led_power == $past(blink));
	endproperty
	a_supply_blink: assert property (p_supply_blink) else $error("power LED not flashing on supply error");
endmodule
`default_nettype wire

// ==== tb/led_viewer.sv ====
/*
 * Operator's view of the front panel: records which levels each LED showed.
 * Assumes clr is driven off the falling edge of sys_clk by the bench.
 */
`timescale 1ns/10ps
`default_nettype none
module led_viewer (
	input  wire logic       sys_clk,
	input  wire logic       clr,
	input  wire logic [5:0] leds,
	output logic      [5:0] seen_hi,
	output logic      [5:0] seen_lo,
	output logic            in_diff
);
	// ==========================================
	// Sampling
	// Both levels seen in one window means the LED flashed
	always_ff @(posedge sys_clk) begin
		if (clr) begin
			seen_hi <= 6'h00;
			seen_lo <= 6'h00;
			in_diff <= 1'h0;
		end else begin
			seen_hi <= seen_hi | leds;
			seen_lo <= seen_lo | ~leds;
			in_diff <= in_diff | (leds[2] ^ leds[1]);
		end
	end
endmodule
`default_nettype wire

// ==== tb/tb_safety_diag_led_indicator.sv ====
/*
 * Self-checking bench of the LED indicator, short blink and quiet counts.
 * Assumes the design files and led_viewer are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_safety_diag_led_indicator;
	typedef struct packed {
		logic [3:0]  e;
		logic        sup, s, m, w;
		logic [1:0]  si;
		logic        rq, on;
		logic [1:0]  ph;
		logic [5:0]  care;
		logic [11:0] pat;
	} row_t;
	// Codes per LED: 01 off, 10 steady, 11 flashing, 00 not looked at
	localparam row_t rows [0:11] = '{
		'{4'h0, 1'h1, 1'h0, 1'h1, 1'h0, 2'h3, 1'h1, 1'h1, 2'h0, 6'h3f, 12'haa9},
		'{4'h0, 1'h1, 1'h0, 1'h0, 1'h1, 2'h1, 1'h0, 1'h0, 2'h0, 6'h3f, 12'h9d9},
		'{4'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h2, 1'h0, 1'h0, 2'h0, 6'h3f, 12'h565},
		'{4'h0, 1'h1, 1'h1, 1'h1, 1'h0, 2'h1, 1'h1, 1'h0, 2'h3, 6'h3f, 12'h9bf},
		'{4'h1, 1'h1, 1'h0, 1'h0, 1'h0, 2'h0, 1'h1, 1'h0, 2'h0, 6'h21, 12'hc02},
		'{4'h2, 1'h1, 1'h0, 1'h0, 1'h0, 2'h0, 1'h1, 1'h0, 2'h0, 6'h11, 12'h302},
		'{4'h3, 1'h1, 1'h0, 1'h0, 1'h0, 2'h0, 1'h1, 1'h0, 2'h0, 6'h19, 12'h3c2},
		'{4'h4, 1'h1, 1'h0, 1'h0, 1'h0, 2'h0, 1'h1, 1'h0, 2'h2, 6'h1f, 12'h3fe},
		'{4'h5, 1'h1, 1'h0, 1'h0, 1'h0, 2'h0, 1'h1, 1'h0, 2'h0, 6'h09, 12'h0c2},
		'{4'h6, 1'h1, 1'h0, 1'h0, 1'h0, 2'h0, 1'h1, 1'h0, 2'h0, 6'h07, 12'h01e},
		'{4'h7, 1'h1, 1'h0, 1'h0, 1'h0, 2'h0, 1'h1, 1'h0, 2'h2, 6'h07, 12'h03e},
		'{4'h8, 1'h1, 1'h0, 1'h0, 1'h0, 2'h0, 1'h1, 1'h0, 2'h0, 6'h1f, 12'h2aa}
	};
	logic       sys_clk, reset, supply_ok, out_request, start_met, start_wait;
	logic [1:0] safety_in, alert_pair, input_xc;
	logic       sync_timeout, interlock_det, supply_err, output_fault;
	logic       ext_output_fault, general_err, start_xc;
	logic [3:0] app_sel, start_sel;
	logic       outputs_on, led_power, led_state, led_start, led_error;
	logic [1:0] led_in;
	logic       clr, in_diff;
	logic [5:0] seen_hi, seen_lo;
	int         err_count, checked, n;

	safety_diag_led_indicator #(.NUM_IN(2), .SEL_W(4), .BLINK_HALF_CYC(4), .INTERLOCK_CYC(10)) u_dut (
		.sys_clk(sys_clk), .reset(reset), .supply_ok(supply_ok), .out_request(out_request),
		.start_met(start_met), .start_wait(start_wait), .safety_in(safety_in),
		.sync_timeout(sync_timeout), .interlock_det(interlock_det), .alert_pair(alert_pair),
		.supply_err(supply_err), .output_fault(output_fault), .ext_output_fault(ext_output_fault),
		.general_err(general_err), .start_xc(start_xc), .input_xc(input_xc), .app_sel(app_sel),
		.start_sel(start_sel), .outputs_on(outputs_on), .led_power(led_power),
		.led_state(led_state), .led_start(led_start), .led_in(led_in), .led_error(led_error)
	);
	led_viewer u_view (
		.sys_clk(sys_clk), .clr(clr),
		.leds({led_power, led_state, led_start, led_in, led_error}),
		.seen_hi(seen_hi), .seen_lo(seen_lo), .in_diff(in_diff)
	);

	// ==========================================
	// Shared tasks
	initial begin
		sys_clk = 1'h0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic chk(input string nm, input logic [11:0] s, input logic [11:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic final_report();
		$display("Checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask

	// Reset also clears every latched error, so each error row starts clean
	task automatic set_row(input row_t r);
		@(negedge sys_clk);
		reset = 1'h1;
		{supply_ok, sync_timeout, start_met, start_wait} = {r.sup, r.s, r.m, r.w};
		{safety_in, out_request, alert_pair, interlock_det} = {r.si, r.rq, 2'h3, 1'h0};
		{supply_err, output_fault, ext_output_fault} = {r.e == 1, r.e == 2, r.e == 3};
		{general_err, start_xc} = {r.e == 4, r.e == 5};
		input_xc = (r.e == 6) ? 2'h1 : (r.e == 7) ? 2'h3 : 2'h0;
		cyc(8);
		reset = 1'h0;
		cyc(3);
		if (r.e == 8)
			app_sel = app_sel ^ 4'h1;
		cyc(4);
	endtask

	// Watches the LEDs for three blink periods, returns one code per LED
	task automatic look(output logic [11:0] v);
		clr = 1'h1;
		cyc(1);
		clr = 1'h0;
		cyc(24);
		for (int i = 0; i < 6; i++)
			v[2*i+:2] = {seen_hi[i], seen_lo[i]};
	endtask

	function automatic logic [11:0] wide(input logic [5:0] c);
		for (int i = 0; i < 6; i++)
			wide[2*i+:2] = {2{c[i]}};
	endfunction

	initial begin
		repeat (5000) @(posedge sys_clk);
		err_count++;
		final_report();
	end

	// ==========================================
	// Tests
	initial begin
		logic [11:0] v;
		err_count = 0;
		checked = 0;
		clr = 1'h0;
		reset = 1'h1;
		app_sel = 4'h3;
		start_sel = 4'h5;
		set_row(rows[0]);
		chk("out reset", {11'h0, outputs_on}, 12'h001);
		foreach (rows[i]) begin
			set_row(rows[i]);
			look(v);
			chk("led pattern", v & wide(rows[i].care), rows[i].pat);
			chk("outputs", {11'h0, outputs_on}, {11'h0, rows[i].on});
			if (rows[i].ph != 2'h0)
				chk("in phase", {11'h0, in_diff}, {11'h0, rows[i].ph[0]});
			$display("Row %0d done", i);
		end
		// Error stays latched after its cause is gone
		set_row(rows[4]);
		supply_err = 1'h0;
		look(v);
		chk("latched", v & wide(6'h21), 12'hc02);
		chk("latched out", {11'h0, outputs_on}, 12'h000);
		$display("Latch test done");
		// Alert ends by itself once the cause is gone
		set_row(rows[3]);
		sync_timeout = 1'h0;
		cyc(3);
		chk("alert exit", {10'h0, outputs_on, led_state}, 12'h003);
		$display("Alert exit test done");
		// Interlock holds outputs off until both inputs are quiet long enough
		set_row(rows[0]);
		interlock_det = 1'h1;
		cyc(1);
		interlock_det = 1'h0;
		look(v);
		chk("interlock", v, 12'h9bf);
		chk("il phase", {10'h0, in_diff, outputs_on}, 12'h000);
		safety_in = 2'h0;
		n = 0;
		while (outputs_on !== 1'h1 && n < 40) begin
			cyc(1);
			n++;
		end
		chk("quiet span", {11'h0, n >= 10 && n < 20}, 12'h001);
		$display("Interlock test done");
		// Power removal: every output drops at once, then follows the inputs again
		reset = 1'h1;
		cyc(1);
		chk("reset outs", {5'h0, outputs_on, led_power, led_state, led_start, led_in, led_error}, 12'h000);
		reset = 1'h0;
		cyc(2);
		chk("after reset", {10'h0, outputs_on, led_state}, 12'h003);
		$display("Reset test done");
		final_report();
	end
endmodule
`default_nettype wire
